// *** inc/pdrs_params.svh ***
// Constants of the power dip restart sequencer
`ifndef PDRS_PARAMS_SVH
`define PDRS_PARAMS_SVH

// ----------------------------------------
// Mode select encodings
// ----------------------------------------
`define PDRS_MODE_TRIP_NOW   2'h0
`define PDRS_MODE_TRIP_AFTER 2'h1
`define PDRS_MODE_DECEL      2'h2
`define PDRS_MODE_RIDE       2'h3

// ----------------------------------------
// Search setting values that enable search
// ----------------------------------------
`define PDRS_SEARCH_SET_A    2'h1
`define PDRS_SEARCH_SET_B    2'h2

// ----------------------------------------
// Widths and event bit positions
// ----------------------------------------
`define PDRS_FREQ_W          16
`define PDRS_EVT_W           4
`define PDRS_EVT_UV          0
`define PDRS_EVT_DIP         1
`define PDRS_EVT_RESTART     2
`define PDRS_EVT_TRIP        3

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PDRS_ADDR_W          4
`define PDRS_REG_STATUS      4'h0
`define PDRS_REG_CLEAR       4'h1
`define PDRS_REG_ENABLE      4'h2
`define PDRS_REG_SAVED       4'h3
`define PDRS_REG_STATE       4'h4

`endif

// *** inc/pdrs_pkg.sv ***
// Types of the power dip restart sequencer
package pdrs_pkg;
	`include "pdrs_params.svh"

	// Sequencer states
	typedef enum logic [2:0] {
		PDRS_RUN,
		PDRS_DECEL,
		PDRS_RIDE,
		PDRS_COAST,
		PDRS_SEARCH,
		PDRS_TRIPPED
	} pdrs_state_t;

	// Inputs from the bus voltage monitor
	typedef struct packed {
		logic below_uv;
		logic below_ride;
		logic restored;
	} pdrs_volt_t;

	// Requests to the output stage
	typedef struct packed {
		logic                     shutdown;
		logic                     decel_req;
		logic                     ride_req;
		logic                     search_req;
		logic                     restart;
		logic                     use_search;
		logic [`PDRS_FREQ_W-1:0]  restart_freq;
	} pdrs_drive_t;
endpackage

// *** rtl/pdrs_sync.sv ***
// Two flip-flop synchroniser for a group of pin levels
module pdrs_sync
	import pdrs_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pdrs_sync_st_t;

	pdrs_sync_st_t st_q;
	pdrs_sync_st_t st_d;

	// Shift stage
	always_comb begin
		st_d    = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.s2;
endmodule // pdrs_sync

// *** rtl/pdrs_regs.sv ***
// Interrupt status, clear and enable registers
module pdrs_regs
	import pdrs_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire logic [`PDRS_EVT_W-1:0]  evt,
	input  wire logic                    clr_we,
	input  wire logic                    en_we,
	input  wire logic [`PDRS_EVT_W-1:0]  wdata,
	output logic      [`PDRS_EVT_W-1:0]  status,
	output logic      [`PDRS_EVT_W-1:0]  enable,
	output logic                         irq
);
	typedef struct packed {
		logic [`PDRS_EVT_W-1:0] status;
		logic [`PDRS_EVT_W-1:0] enable;
		logic                   irq;
	} pdrs_regs_st_t;

	pdrs_regs_st_t st_q;
	pdrs_regs_st_t st_d;

	// Sticky bits, set wins over clear
	always_comb begin
		st_d = st_q;
		if (clr_we) begin
			st_d.status = st_q.status & ~wdata;
		end
		st_d.status = st_d.status | evt;
		if (en_we) begin
			st_d.enable = wdata;
		end
		st_d.irq = |(st_d.status & st_d.enable);
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign status = st_q.status;
	assign enable = st_q.enable;
	assign irq    = st_q.irq;
endmodule // pdrs_regs

// *** rtl/pdrs_top.sv ***
// Momentary power dip restart sequencer
//
// Behaviour
// R1 - In mode 0 an undervoltage raises the alarm and shuts the output so the motor coasts.
// R2 - In mode 1 an undervoltage shuts the output without entering undervoltage or raising the alarm.
// R3 - In mode 1 the alarm rises when supply returns and the output stays shut.
// R4 - In mode 2 a dip below the ride-through level starts a regenerating deceleration.
// R5 - In mode 2 the end of that deceleration reports undervoltage.
// R6 - In mode 3 a dip below the ride-through level starts ride-through running until supply returns.
// R7 - In mode 3 undervoltage during ride-through saves the output frequency, shuts the output and coasts.
// R8 - Without search, a run command at restoration restarts at the saved frequency.
// R9 - With search, a run command at restoration searches the coasting speed and restarts from it.
// R10 - Search is on when the search input is high or the search setting is 1 or 2.
// R11 - Without a run command at restoration the output stays shut and no restart happens; the code keeps coasting and restarts once run_cmd rises.
module pdrs_top
	import pdrs_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic                      below_uv_level,
	input  wire logic                      below_ride_through_voltage_level,
	input  wire logic                      power_restored,
	input  wire logic                      run_cmd,
	input  wire logic                      idle_speed_search_enable_input,
	input  wire logic [1:0]                starting_mode_search_setting,
	input  wire logic [1:0]                power_dip_mode_select,
	input  wire logic [`PDRS_FREQ_W-1:0]   output_freq,
	input  wire logic                      decel_done,
	input  wire logic                      search_done,
	input  wire logic [`PDRS_FREQ_W-1:0]   searched_freq,
	input  wire logic [`PDRS_ADDR_W-1:0]   reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [31:0]               reg_rdata,
	output logic                           output_shutdown,
	output logic                           uv_alarm,
	output logic                           decel_req,
	output logic                           ride_req,
	output logic                           search_req,
	output logic                           restart_pulse,
	output logic                           restart_use_search,
	output logic      [`PDRS_FREQ_W-1:0]   restart_freq,
	output logic      [`PDRS_FREQ_W-1:0]   saved_freq,
	output logic                           irq
);
	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	// Synchronised pin levels
	logic [4:0]  pins_s;
	logic        srch_pin_s;
	pdrs_volt_t  volt;
	logic        run_s;
	logic [1:0]  srch_set_s;
	logic [1:0]  mode_s;

	// Pins are asynchronous, two stages before any decode
	pdrs_sync #(
		.W(5)
	) u_sync_bits (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.async_in ({below_uv_level, below_ride_through_voltage_level, power_restored,
		            run_cmd, idle_speed_search_enable_input}),
		.sync_out (pins_s)
	);

	// Mode and search setting selects
	pdrs_sync #(
		.W(4)
	) u_sync_sel (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.async_in ({starting_mode_search_setting, power_dip_mode_select}),
		.sync_out ({srch_set_s, mode_s})
	);

	// Unpack synchronised levels
	assign volt.below_uv   = pins_s[4];
	assign volt.below_ride = pins_s[3];
	assign volt.restored   = pins_s[2];
	assign run_s           = pins_s[1];
	assign srch_pin_s      = pins_s[0];

	// ----------------------------------------
	// Search enable
	// ----------------------------------------
	// Search enable decode
	function automatic logic search_on(input logic pin, input logic [1:0] setting);
		search_on = pin || (setting == `PDRS_SEARCH_SET_A) || (setting == `PDRS_SEARCH_SET_B); // [R10]
	endfunction

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	// Everything the sequencer remembers
	typedef struct packed {
		pdrs_state_t             state;
		logic                    alarm;
		logic [`PDRS_FREQ_W-1:0] saved;
		pdrs_drive_t             drv;
		logic [`PDRS_EVT_W-1:0]  evt;
		logic [31:0]             rdata;
	} pdrs_st_t;

	// Current and next sequencer state
	pdrs_st_t st_q;
	pdrs_st_t st_d;

	// Interrupt register views and write strobes
	logic [`PDRS_EVT_W-1:0] status;
	logic [`PDRS_EVT_W-1:0] enable;
	logic                   clr_we;
	logic                   en_we;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	// Register write decode
	assign clr_we = reg_wr && (reg_addr == `PDRS_REG_CLEAR);
	assign en_we  = reg_wr && (reg_addr == `PDRS_REG_ENABLE);

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	// Next state and outputs
	always_comb begin
		// Hold state, clear one-cycle pulses
		st_d                  = st_q;
		st_d.evt              = '0;
		st_d.drv.restart      = 1'b0;
		// State transitions
		case (st_q.state)
			// Normal running, watch for a dip
			PDRS_RUN: begin
				if (mode_s == `PDRS_MODE_TRIP_NOW && volt.below_uv) begin
					// Mode 0 trips at once
					st_d.state                 = PDRS_TRIPPED; // [R1]
					st_d.alarm                 = 1'b1; // [R1]
					st_d.drv.shutdown          = 1'b1; // [R1]
					st_d.evt[`PDRS_EVT_UV]     = 1'b1;
					st_d.evt[`PDRS_EVT_TRIP]   = 1'b1;
				end else if (mode_s == `PDRS_MODE_TRIP_AFTER && volt.below_uv) begin
					// Mode 1 shuts the output, alarm deferred
					st_d.state                 = PDRS_COAST; // [R2]
					st_d.drv.shutdown          = 1'b1; // [R2]
					st_d.evt[`PDRS_EVT_DIP]    = 1'b1;
				end else if (mode_s == `PDRS_MODE_DECEL && volt.below_ride) begin
					// Mode 2 decelerates on regenerated energy
					st_d.state                 = PDRS_DECEL; // [R4]
					st_d.drv.decel_req         = 1'b1; // [R4]
					st_d.evt[`PDRS_EVT_DIP]    = 1'b1;
				end else if (mode_s == `PDRS_MODE_RIDE && volt.below_ride) begin
					// Mode 3 rides through the dip
					st_d.state                 = PDRS_RIDE; // [R6]
					st_d.drv.ride_req          = 1'b1; // [R6]
					st_d.evt[`PDRS_EVT_DIP]    = 1'b1;
				end
			end

			// Controlled deceleration in progress
			PDRS_DECEL: begin
				if (decel_done) begin
					// Stopped, report undervoltage and trip
					st_d.state                 = PDRS_TRIPPED; // [R5]
					st_d.alarm                 = 1'b1; // [R5]
					st_d.drv.decel_req         = 1'b0;
					st_d.drv.shutdown          = 1'b1;
					st_d.evt[`PDRS_EVT_UV]     = 1'b1;
					st_d.evt[`PDRS_EVT_TRIP]   = 1'b1;
				end
			end

			// Ride-through running on regenerated energy
			PDRS_RIDE: begin
				if (volt.below_uv) begin
					// Energy exhausted, save frequency and coast
					st_d.saved                 = output_freq; // [R7]
					st_d.state                 = PDRS_COAST; // [R7]
					st_d.drv.ride_req          = 1'b0;
					st_d.drv.shutdown          = 1'b1; // [R7]
					st_d.evt[`PDRS_EVT_UV]     = 1'b1;
				end else if (volt.restored && !volt.below_ride) begin
					// Supply back before undervoltage, keep running
					st_d.state                 = PDRS_RUN;
					st_d.drv.ride_req          = 1'b0;
				end
			end

			// Output shut, motor coasting; outside mode 1 a restore without a run
			// command keeps coasting until the command appears
			PDRS_COAST: begin
				if (volt.restored && !volt.below_uv) begin
					// Mode 1 trips now, others wait for a run command
					if (mode_s == `PDRS_MODE_TRIP_AFTER) begin
						st_d.state               = PDRS_TRIPPED; // [R3]
						st_d.alarm               = 1'b1; // [R3]
						st_d.evt[`PDRS_EVT_UV]   = 1'b1;
						st_d.evt[`PDRS_EVT_TRIP] = 1'b1;
					end else if (!run_s) begin
						// No run command, keep coasting
						st_d.state               = PDRS_COAST; // [R11]
					end else if (search_on(srch_pin_s, srch_set_s)) begin
						// Find the coasting speed first
						st_d.state               = PDRS_SEARCH; // [R9]
						st_d.drv.search_req      = 1'b1; // [R9]
					end else begin
						// Restart at the saved frequency
						st_d.state               = PDRS_RUN; // [R8]
						st_d.drv.shutdown        = 1'b0;
						st_d.drv.restart         = 1'b1;
						st_d.drv.use_search      = 1'b0;
						st_d.drv.restart_freq    = st_q.saved; // [R8]
						st_d.evt[`PDRS_EVT_RESTART] = 1'b1;
					end
				end
			end

			// Speed search in progress
			PDRS_SEARCH: begin
				if (volt.below_uv) begin
					// Supply lost again, back to coasting
					st_d.state                 = PDRS_COAST;
					st_d.drv.search_req        = 1'b0;
				end else if (search_done) begin
					// Restart from the searched speed
					st_d.state                 = PDRS_RUN; // [R9]
					st_d.drv.search_req        = 1'b0;
					st_d.drv.shutdown          = 1'b0;
					st_d.drv.restart           = 1'b1;
					st_d.drv.use_search        = 1'b1;
					st_d.drv.restart_freq      = searched_freq; // [R9]
					st_d.evt[`PDRS_EVT_RESTART] = 1'b1;
				end
			end

			// Held until reset
			PDRS_TRIPPED: begin
				st_d.drv.shutdown = 1'b1;
				st_d.alarm        = 1'b1;
			end

			// Unused codes fail safe
			default: begin
				st_d.state = PDRS_TRIPPED;
			end
		endcase

		// Register read, data in the next cycle
		st_d.rdata = '0;
		if (reg_rd) begin
			// Unmapped addresses read zero
			case (reg_addr)
				`PDRS_REG_STATUS: st_d.rdata = {{(32-`PDRS_EVT_W){1'b0}}, status};
				`PDRS_REG_ENABLE: st_d.rdata = {{(32-`PDRS_EVT_W){1'b0}}, enable};
				`PDRS_REG_SAVED:  st_d.rdata = {{(32-`PDRS_FREQ_W){1'b0}}, st_q.saved};
				`PDRS_REG_STATE:  st_d.rdata = {28'h0000000, st_q.alarm, 3'(st_q.state)};
				default:          st_d.rdata = '0;
			endcase
		end
	end

	// ----------------------------------------
	// Registered state
	// ----------------------------------------
	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q       <= '0;
			st_q.state <= PDRS_RUN;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// Interrupt registers
	// ----------------------------------------
	pdrs_regs u_regs (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.evt    (st_q.evt),
		.clr_we (clr_we),
		.en_we  (en_we),
		.wdata  (reg_wdata[`PDRS_EVT_W-1:0]),
		.status (status),
		.enable (enable),
		.irq    (irq)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Outputs straight from flip-flops
	assign reg_rdata          = st_q.rdata;
	assign output_shutdown    = st_q.drv.shutdown;
	assign uv_alarm           = st_q.alarm;
	assign decel_req          = st_q.drv.decel_req;
	assign ride_req           = st_q.drv.ride_req;
	assign search_req         = st_q.drv.search_req;
	assign restart_pulse      = st_q.drv.restart;
	assign restart_use_search = st_q.drv.use_search;
	assign restart_freq       = st_q.drv.restart_freq;
	assign saved_freq         = st_q.saved;
endmodule // pdrs_top

// *** testbench/pdrs_top_sva.sv ***
// Assertion checker of the power dip restart sequencer
module pdrs_top_sva
	import pdrs_pkg::*;
(
	input wire logic                    mclk,
	input wire logic                    rst_n,
	input wire logic                    below_uv_level,
	input wire logic                    below_ride_through_voltage_level,
	input wire logic                    power_restored,
	input wire logic                    run_cmd,
	input wire logic [1:0]              power_dip_mode_select,
	input wire logic [`PDRS_FREQ_W-1:0] output_freq,
	input wire logic                    decel_done,
	input wire logic [`PDRS_FREQ_W-1:0] searched_freq,
	input wire logic                    reg_rd,
	input wire logic [31:0]             reg_rdata,
	input wire logic                    output_shutdown,
	input wire logic                    uv_alarm,
	input wire logic                    decel_req,
	input wire logic                    ride_req,
	input wire logic                    search_req,
	input wire logic                    restart_pulse,
	input wire logic                    restart_use_search,
	input wire logic [`PDRS_FREQ_W-1:0] restart_freq,
	input wire logic [`PDRS_FREQ_W-1:0] saved_freq
);
	// Short names of the pin levels
	wire [1:0] m  = power_dip_mode_select;
	wire       uv = below_uv_level;
	wire       rd = below_ride_through_voltage_level;
	wire       rs = power_restored;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Sequencer reactions
	// ----------------------------------------
	a_trip_now: assert property ((m == 2'h0 && uv)[*3] |=> uv_alarm && output_shutdown)
		else $error("mode 0 dip without alarm and shutdown");
	a_trip_defer: assert property ((m == 2'h1 && uv && !rs)[*3] |=> output_shutdown && !uv_alarm)
		else $error("mode 1 dip wrong reaction");
	a_late_alarm: assert property ($rose(uv_alarm) && m == 2'h1 |-> $past(rs, 3) && output_shutdown)
		else $error("mode 1 alarm before restore");
	a_decel_start: assert property ((m == 2'h2 && rd && !uv_alarm)[*3] |=> decel_req || uv_alarm)
		else $error("mode 2 deceleration not requested");
	a_decel_end: assert property ($fell(decel_req) |-> $past(decel_done) && uv_alarm && output_shutdown)
		else $error("deceleration end without alarm");
	a_ride_start: assert property ((m == 2'h3 && rd && !uv && !rs)[*3] |=> ride_req)
		else $error("mode 3 ride-through not requested");
	a_ride_save: assert property ($fell(ride_req) && output_shutdown |-> saved_freq == $past(output_freq))
		else $error("frequency not saved at undervoltage");
	a_plain_restart: assert property (restart_pulse && !restart_use_search |-> restart_freq == saved_freq)
		else $error("restart not at saved frequency");
	a_search_restart: assert property (restart_pulse && restart_use_search |->
		$past(search_req) && restart_freq == $past(searched_freq))
		else $error("restart not at searched frequency");
	a_run_needed: assert property (restart_pulse |-> $past(run_cmd, 3) && !output_shutdown)
		else $error("restart without run command");
	a_pulse_single: assert property (restart_pulse |=> !restart_pulse)
		else $error("restart pulse longer than one cycle");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read answer cycle");
endmodule // pdrs_top_sva

bind pdrs_top pdrs_top_sva pdrs_top_sva_inst (.*);

// *** testbench/pdrs_model.sv ***
// Bus voltage monitor and output stage model of the sequencer
module pdrs_model
	import pdrs_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire logic [1:0]              volt,
	input  wire logic [3:0]              dly,
	input  wire logic [`PDRS_FREQ_W-1:0] sf,
	input  wire logic                    decel_req,
	input  wire logic                    search_req,
	output logic                         below_uv_level,
	output logic                         below_ride_through_voltage_level,
	output logic                         power_restored,
	output logic                         decel_done,
	output logic                         search_done,
	output logic [`PDRS_FREQ_W-1:0]      searched_freq
);
	logic [3:0] cnt_q;

	// Voltage code: 0 nominal, 1 sag, 2 undervoltage, 3 restored
	assign below_uv_level = volt == 2'h2;
	assign below_ride_through_voltage_level = volt == 2'h1 || volt == 2'h2;
	assign power_restored = volt == 2'h3;

	// Request age, answered after dly cycles
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			cnt_q <= 4'h0;
		else
			cnt_q <= (decel_req || search_req) ? cnt_q + 4'h1 : 4'h0;
	end
	assign decel_done = decel_req && cnt_q == dly;
	assign search_done = search_req && cnt_q == dly;
	// Speed is stale outside its valid cycle
	assign searched_freq = search_done ? sf : ~sf;
endmodule // pdrs_model

// *** testbench/pdrs_top_tb.sv ***
// Self-checking testbench of the power dip restart sequencer
module pdrs_top_tb
	import pdrs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        mclk, rst_n, run_cmd, idle_speed_search_enable_input, reg_wr, reg_rd, rd_q;
	logic [1:0]  starting_mode_search_setting, power_dip_mode_select, volt;
	logic [3:0]  reg_addr, dly;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] output_freq, sf, searched_freq, restart_freq, saved_freq;
	logic        below_uv_level, below_ride_through_voltage_level, power_restored, decel_done;
	logic        search_done, output_shutdown, uv_alarm, decel_req, ride_req, search_req;
	logic        restart_pulse, restart_use_search, irq;
	logic [63:0] rq[$];
	logic [16:0] pq[$];
	logic [63:0] e;
	int          errors, total_checks;

	pdrs_top pdrs_top_inst (.*);
	pdrs_model pdrs_model_inst (.*);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input string n, input logic [31:0] x, g);
		total_checks++;
		if (g !== x) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] mk, x);
		rq.push_back({mk, x});
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
	endtask
	task end_sim;
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One dip: sag, undervoltage, restore
	task run_case(input logic [1:0] md, src, input logic rn);
		logic [15:0] f;
		f = $urandom;
		rst_n <= 1'b0;
		power_dip_mode_select <= md;
		run_cmd <= rn;
		idle_speed_search_enable_input <= src == 2'h1;
		starting_mode_search_setting <= src > 2'h1 ? src - 2'h1 : {2{f[0] & ~src[0]}};
		output_freq <= f;
		sf <= $urandom;
		dly <= $urandom;
		volt <= 2'h0;
		w(16);
		rst_n <= 1'b1;
		w(4);
		volt <= 2'h1;
		w(24);
		if (md == 2'h3)
			chk("ride_req", 1, ride_req);
		chk("decel alarm", md == 2'h2, uv_alarm);
		volt <= 2'h2;
		w(8);
		chk("output_shutdown", 1, output_shutdown);
		chk("uv_alarm", md[0] == 1'b0, uv_alarm);
		if (md == 2'h3)
			rd(4'h3, 32'hFFFF, f);
		if (md == 2'h3 && rn)
			pq.push_back({src != 2'h0, src != 2'h0 ? sf : f});
		volt <= 2'h3;
		w(40);
		chk("uv_alarm", md != 2'h3, uv_alarm);
		chk("output_shutdown", !(md == 2'h3 && rn), output_shutdown);
		chk("restart count", 0, pq.size());
		if (md != 2'h0)
			rd(4'h0, 32'hF, md == 2'h3 ? {29'h0, rn, 2'h3} : 32'hB);
		if (md == 2'h0) begin
			chk("irq", 0, irq);
			wr(4'h2, 32'h1);
			chk("irq", 1, irq);
			rd(4'h2, 32'hF, 32'h1);
			rd(4'h0, 32'h1, 32'h1);
			rd(4'h4, 32'hF, 32'hD);
			rd(4'hF, 32'hFFFFFFFF, 32'h0);
			wr(4'h1, 32'hF);
			chk("irq", 0, irq);
			rd(4'h0, 32'hF, 32'h0);
		end
	endtask

	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge mclk) begin
		rd_q <= reg_rd;
		if (rd_q) begin
			e = rq.pop_front();
			chk("reg_rdata", e[31:0], reg_rdata & e[63:32]);
		end
		if (restart_pulse !== 1'b0 && pq.size() == 0)
			chk("restart_pulse", 0, 1);
		else if (restart_pulse !== 1'b0)
			chk("restart", pq.pop_front(), {restart_use_search, restart_freq});
	end

	// Clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		end_sim();
	end

	// Main sequence over modes, search sources and run command
	initial begin
		{rst_n, run_cmd, idle_speed_search_enable_input, reg_wr, reg_rd} <= 5'h0;
		{starting_mode_search_setting, power_dip_mode_select, volt, reg_addr, dly} <= 14'h0;
		{reg_wdata, output_freq, sf} <= 64'h0;
		void'($urandom(32'h079345F6));
		for (int i = 0; i < 32; i++)
			run_case(i[4:3], i[2:1], i[0]);
		end_sim();
	end
endmodule // pdrs_top_tb
